// ==== verilog/bcw_pkg.sv ====
package bcw_pkg;
   localparam logic [3:0] BCW_ADDR_CTRL = 4'h0;
   localparam logic [3:0] BCW_ADDR_STAT = 4'h4;
   localparam logic [7:0] BCW_CTRL_RESET = 8'hEB;
   localparam int BCW_BIT_PFQ = 7;
   localparam int BCW_BIT_BC = 6;
   localparam int BCW_POS_WR = 4;
   localparam int BCW_POS_RD = 2;
   localparam int BCW_POS_CW = 0;
   localparam logic [2:0] BCW_DATA_BASE = 3'h4;
   localparam logic [2:0] BCW_CODE_BASE = 3'h3;
   localparam logic [31:0] BCW_UNMAPPED = 32'h0000_0000;

   typedef enum logic [1:0]
   {
      BCW_FETCH = 2'h0,
      BCW_CONST = 2'h1,
      BCW_DREAD = 2'h2,
      BCW_DWRITE = 2'h3
   } bcw_kind_t;

   typedef struct packed
   {
      logic prefetch_enable;
      logic branch_cache_enable;
      logic [1:0] write_wait_sel;
      logic [1:0] read_wait_sel;
      logic [1:0] code_wait_sel;
   } bcw_ctrl_t;
endpackage : bcw_pkg

// ==== verilog/bcw_len.sv ====
`timescale 1ns/1ps
module bcw_len
(
   input wire bcw_pkg::bcw_ctrl_t i_ctrl,
   input wire bcw_pkg::bcw_kind_t i_kind,
   output logic [2:0] o_len
);
   // Same selection for every address: no address input
   always_comb
   begin
      case (i_kind)
         bcw_pkg::BCW_DWRITE: o_len = bcw_pkg::BCW_DATA_BASE + {1'b0, i_ctrl.write_wait_sel};
         bcw_pkg::BCW_DREAD: o_len = bcw_pkg::BCW_DATA_BASE + {1'b0, i_ctrl.read_wait_sel};
         bcw_pkg::BCW_CONST:
         begin
            if (i_ctrl.code_wait_sel == 2'h0)
               o_len = bcw_pkg::BCW_DATA_BASE;
            else
               o_len = bcw_pkg::BCW_CODE_BASE + {1'b0, i_ctrl.code_wait_sel};
         end
         default: o_len = bcw_pkg::BCW_CODE_BASE + {1'b0, i_ctrl.code_wait_sel};
      endcase
   end
endmodule : bcw_len

// ==== verilog/bcw_top.sv ====
`timescale 1ns/1ps
module bcw_top
(
   input wire i_clk_sys,
   input wire i_rstn,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire i_cyc_start,
   input wire bcw_pkg::bcw_kind_t i_cyc_kind,
   input wire i_pfq_stall,
   input wire i_fetch_abort,
   input wire [7:0] i_bus_data,
   output logic o_strobe_code,
   output logic o_strobe_rd,
   output logic o_strobe_wr,
   output logic o_cyc_done,
   output logic o_to_queue,
   output logic o_to_core,
   output logic [7:0] o_data,
   output logic o_prefetch_enable,
   output logic o_branch_cache_enable
);
   typedef enum logic [1:0]
   {
      BCW_IDLE = 2'b00,
      BCW_RUN = 2'b01,
      BCW_STALL = 2'b11
   } bcw_state_t;

   bcw_pkg::bcw_ctrl_t bus_cycle_control;
   bcw_state_t state;
   bcw_pkg::bcw_kind_t kind;
   logic [2:0] count;
   logic [2:0] target;
   logic [2:0] next_len;
   logic ack;
   logic busy;

   bcw_len u_len
   (
      .i_ctrl(bus_cycle_control),
      .i_kind(i_cyc_kind),
      .o_len(next_len)
   );

   assign busy = (state != BCW_IDLE);

   // One wait state per access: waitrequest drops for exactly one edge
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rstn)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
   end

   always_comb
   begin
      ack = !avs_waitrequest;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rstn)
         bus_cycle_control <= bcw_pkg::BCW_CTRL_RESET;
      else if (avs_write && ack && avs_address == bcw_pkg::BCW_ADDR_CTRL)
         bus_cycle_control <= avs_writedata[7:0];
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rstn)
         avs_readdata <= bcw_pkg::BCW_UNMAPPED;
      else if (avs_read && !ack)
      begin
         case (avs_address)
            bcw_pkg::BCW_ADDR_CTRL: avs_readdata <= {24'h00_0000, bus_cycle_control};
            bcw_pkg::BCW_ADDR_STAT: avs_readdata <= {24'h00_0000, 1'b0, busy, kind, 1'b0, count};
            default: avs_readdata <= bcw_pkg::BCW_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rstn)
      begin
         o_prefetch_enable <= 1'b1;
         o_branch_cache_enable <= 1'b1;
      end
      else
      begin
         o_prefetch_enable <= bus_cycle_control.prefetch_enable;
         o_branch_cache_enable <= bus_cycle_control.branch_cache_enable;
      end
   end

   // Length is latched at cycle start so a later register write cannot change it
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rstn)
      begin
         state <= BCW_IDLE;
         kind <= bcw_pkg::BCW_FETCH;
         count <= 3'h0;
         target <= 3'h0;
      end
      else
      begin
         case (state)
            BCW_IDLE:
            begin
               if (i_cyc_start)
               begin
                  state <= BCW_RUN;
                  kind <= i_cyc_kind;
                  target <= next_len;
                  count <= 3'h1;
               end
            end
            BCW_RUN:
            begin
               if (kind == bcw_pkg::BCW_FETCH && i_fetch_abort)
                  state <= BCW_IDLE;
               else if (count == target)
               begin
                  if ((kind == bcw_pkg::BCW_FETCH || kind == bcw_pkg::BCW_CONST) && i_pfq_stall)
                     state <= BCW_STALL;
                  else
                     state <= BCW_IDLE;
               end
               else
                  count <= count + 3'h1;
            end
            BCW_STALL:
            begin
               if (!i_pfq_stall)
                  state <= BCW_IDLE;
            end
            default: state <= BCW_IDLE;
         endcase
      end
   end

   logic ending;
   assign ending = (state == BCW_RUN && count == target && !(kind == bcw_pkg::BCW_FETCH && i_fetch_abort)
                    && !((kind == bcw_pkg::BCW_FETCH || kind == bcw_pkg::BCW_CONST) && i_pfq_stall))
                   || (state == BCW_STALL && !i_pfq_stall);

   logic next_active;
   assign next_active = (state == BCW_IDLE) ? i_cyc_start : !(ending || (state == BCW_RUN
                        && kind == bcw_pkg::BCW_FETCH && i_fetch_abort));

   bcw_pkg::bcw_kind_t next_kind;
   assign next_kind = (state == BCW_IDLE) ? i_cyc_kind : kind;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rstn)
      begin
         o_strobe_code <= 1'b0;
         o_strobe_rd <= 1'b0;
         o_strobe_wr <= 1'b0;
      end
      else
      begin
         o_strobe_code <= next_active && (next_kind == bcw_pkg::BCW_FETCH || next_kind == bcw_pkg::BCW_CONST);
         o_strobe_rd <= next_active && next_kind == bcw_pkg::BCW_DREAD;
         o_strobe_wr <= next_active && next_kind == bcw_pkg::BCW_DWRITE;
      end
   end

   // Fetched bytes go to the queue; constant and data reads go to the core
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rstn)
      begin
         o_cyc_done <= 1'b0;
         o_to_queue <= 1'b0;
         o_to_core <= 1'b0;
         o_data <= 8'h00;
      end
      else
      begin
         o_cyc_done <= ending;
         o_to_queue <= ending && kind == bcw_pkg::BCW_FETCH;
         o_to_core <= ending && (kind == bcw_pkg::BCW_CONST || kind == bcw_pkg::BCW_DREAD);
         if (ending)
            o_data <= i_bus_data;
      end
   end

   a_write_len: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      state == BCW_IDLE && i_cyc_start && i_cyc_kind == bcw_pkg::BCW_DWRITE
      |=> target == 3'h4 + {1'b0, $past(bus_cycle_control.write_wait_sel)})
      else $error("write length wrong");
   a_read_len: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      state == BCW_IDLE && i_cyc_start && i_cyc_kind == bcw_pkg::BCW_DREAD
      |=> target == 3'h4 + {1'b0, $past(bus_cycle_control.read_wait_sel)})
      else $error("read length wrong");
   a_code_fast: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      state == BCW_IDLE && i_cyc_start && bus_cycle_control.code_wait_sel == 2'h0
      && (i_cyc_kind == bcw_pkg::BCW_FETCH || i_cyc_kind == bcw_pkg::BCW_CONST)
      |=> target == ((kind == bcw_pkg::BCW_CONST) ? 3'h4 : 3'h3))
      else $error("code 00b length wrong");
   a_code_len: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      state == BCW_IDLE && i_cyc_start && bus_cycle_control.code_wait_sel != 2'h0
      && (i_cyc_kind == bcw_pkg::BCW_FETCH || i_cyc_kind == bcw_pkg::BCW_CONST)
      |=> target == 3'h3 + {1'b0, $past(bus_cycle_control.code_wait_sel)})
      else $error("code length wrong");
   a_stall_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      state == BCW_STALL && i_pfq_stall |=> state == BCW_STALL && o_strobe_code)
      else $error("stall not held");
   a_count_end: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      state == BCW_RUN && count == target && !i_pfq_stall && !i_fetch_abort
      |=> state == BCW_IDLE && !o_strobe_code && !o_strobe_rd && !o_strobe_wr)
      else $error("cycle did not end");
   a_len_stable: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      state == BCW_RUN && $past(state) == BCW_RUN |-> $stable(target))
      else $error("length changed mid cycle");
   a_reset_ctrl: assert property (@(posedge i_clk_sys)
      !i_rstn |=> bus_cycle_control == bcw_pkg::BCW_CTRL_RESET)
      else $error("reset value wrong");
   a_queue_route: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      o_to_queue |-> !o_to_core && $past(kind) == bcw_pkg::BCW_FETCH)
      else $error("byte routed wrong");
   a_enable_out: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      ##1 o_prefetch_enable == $past(bus_cycle_control.prefetch_enable))
      else $error("prefetch enable mismatch");

   c_write: cover property (@(posedge i_clk_sys) o_strobe_wr ##1 !o_strobe_wr);
   c_stall: cover property (@(posedge i_clk_sys) state == BCW_STALL);
   c_abort: cover property (@(posedge i_clk_sys) state == BCW_RUN && kind == bcw_pkg::BCW_FETCH && i_fetch_abort);
   c_const: cover property (@(posedge i_clk_sys) o_to_core && $past(kind) == bcw_pkg::BCW_CONST);
endmodule : bcw_top

// ==== tb/bcw_mem_model.sv ====
`timescale 1ns/1ps
module bcw_mem_model
(
   input wire i_clk_sys,
   input wire i_rstn,
   input wire i_active,
   output logic [7:0] o_byte
);
   logic [7:0] seq;
   // Holds a fresh byte while selected and toggles when released
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rstn)
      begin
         seq <= 8'h5a;
         o_byte <= 8'h00;
      end
      else if (!i_active)
      begin
         seq <= seq + 8'h3b;
         o_byte <= ~o_byte;
      end
      else if (o_byte != seq)
      begin
         o_byte <= seq;
      end
   end
endmodule : bcw_mem_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic i_clk_sys, i_rstn, avs_read, avs_write, i_cyc_start, i_pfq_stall, i_fetch_abort;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic avs_waitrequest, o_strobe_code, o_strobe_rd, o_strobe_wr, o_cyc_done, o_to_queue, o_to_core;
   logic o_prefetch_enable, o_branch_cache_enable;
   logic [7:0] i_bus_data, o_data, cur;
   bcw_pkg::bcw_kind_t i_cyc_kind;
   int n_fail, samples_checked, cyc, seed, i, k;
   logic [7:0] tbl [8] = '{8'hd6, 8'hc1, 8'heb, 8'hc0, 8'h3f, 8'h00, 8'hff, 8'h7e};
   bcw_top bcw_top_inst (.*);
   bcw_mem_model bcw_mem_model_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
      .i_active(o_strobe_code | o_strobe_rd | o_strobe_wr), .o_byte(i_bus_data));
   initial
   begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   always @(posedge i_clk_sys)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_fail++;
         test_done();
      end
   end
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do
         @(posedge i_clk_sys);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   function automatic int exp_len(input logic [7:0] c, input int kd);
      if (kd == 3)
         return 4 + c[5:4];
      if (kd == 2)
         return 4 + c[3:2];
      if (c[1:0] == 2'h0)
         return (kd == 0) ? 3 : 4;
      return 3 + c[1:0];
   endfunction : exp_len
   task automatic run_cyc(input int kd, input int extra, input bit ab);
      int n, w, dn, e;
      logic sel;
      logic [7:0] b;
      n = 0;
      w = 0;
      dn = 0;
      e = exp_len(cur, kd);
      @(posedge i_clk_sys);
      i_cyc_start <= 1'b1;
      i_cyc_kind <= bcw_pkg::bcw_kind_t'(kd);
      i_pfq_stall <= (extra > 0);
      @(posedge i_clk_sys);
      i_cyc_start <= 1'b0;
      repeat (40)
      begin
         @(negedge i_clk_sys);
         sel = (kd < 2) ? o_strobe_code : (kd == 2) ? o_strobe_rd : o_strobe_wr;
         w += int'((o_strobe_code | o_strobe_rd | o_strobe_wr) & !sel);
         if (sel)
         begin
            n++;
            b = i_bus_data;
         end
         if (o_cyc_done)
         begin
            dn++;
            if (kd != 3)
               check("data", {24'h0, b}, {24'h0, o_data});
            if (kd != 3)
               check("route", {30'h0, kd == 0, kd != 0}, {30'h0, o_to_queue, o_to_core});
         end
         @(posedge i_clk_sys);
         if (n >= e + extra)
            i_pfq_stall <= 1'b0;
         i_fetch_abort <= ab && n == 2;
      end
      check("other strobe", 0, w);
      if (ab)
         check("abort", 32'h0000_0003, {30'h0, n < e, dn == 0});
      else if (extra > 0)
         check("stall len", 1, n >= e + extra && n <= e + extra + 1);
      else
         check("len", e, n);
   endtask : run_cyc
   initial
   begin
      seed = 32'h49cd_9c6f;
      {i_rstn, avs_read, avs_write, i_cyc_start, i_pfq_stall, i_fetch_abort} = 6'h00;
      avs_address = 4'h0;
      avs_writedata = 32'h0000_0000;
      i_cyc_kind = bcw_pkg::BCW_FETCH;
      repeat (2) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      bus(1'b0, bcw_pkg::BCW_ADDR_CTRL, 32'h0);
      check("ctrl reset", 32'h0000_00eb, q);
      check("enables reset", 2'h3, {o_prefetch_enable, o_branch_cache_enable});
      cur = 8'heb;
      run_cyc(0, 0, 0);
      bus(1'b0, 4'h8, 32'h0);
      check("unmapped", bcw_pkg::BCW_UNMAPPED, q);
      $display("Reset test done");
      for (i = 0; i < 30; i++)
      begin
         cur = (i < 8) ? tbl[i] : 8'($random(seed));
         bus(1'b1, bcw_pkg::BCW_ADDR_CTRL, {24'($random(seed)), cur});
         bus(1'b0, bcw_pkg::BCW_ADDR_CTRL, 32'h0);
         check("ctrl rw", {24'h0, cur}, q);
         check("enables", cur[7:6], {o_prefetch_enable, o_branch_cache_enable});
         for (k = 0; k < 4; k++)
            run_cyc(k, 0, 0);
         run_cyc(i % 2, 1 + i % 3, 0);
      end
      $display("Cycle length test done");
      @(posedge i_clk_sys);
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      bus(1'b0, bcw_pkg::BCW_ADDR_CTRL, 32'h0);
      check("ctrl mid reset", {24'h0, bcw_pkg::BCW_CTRL_RESET}, q);
      $display("Mid-run reset test done");
      cur = 8'hc3;
      bus(1'b1, bcw_pkg::BCW_ADDR_CTRL, 32'h0000_00c3);
      run_cyc(0, 0, 1);
      fork
         run_cyc(2, 0, 0);
         begin
            @(posedge i_clk_sys);
            bus(1'b1, bcw_pkg::BCW_ADDR_CTRL, 32'h0000_00ff);
         end
      join
      cur = 8'hff;
      run_cyc(2, 0, 0);
      bus(1'b0, bcw_pkg::BCW_ADDR_STAT, 32'h0);
      check("status", 32'h0000_0027, q);
      $display("Abort and update test done");
      test_done();
   end
endmodule : testbench
